// File: design/thresh_pkg.sv
// Purpose : Constants for the threshold window compare block
// Assumes : Byte-wide register port, 8-bit register offsets
// Notes   : Offsets, resets and field positions are named once here
package thresh_pkg;
    // ************************************************************
    // Widths
    // ************************************************************
    localparam int PROX_W  = 11;
    localparam int LIGHT_W = 16;
    localparam int PERS_W  = 4;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] INT_CTRL_ADDR      = 8'h98;
    localparam logic [7:0] PROX_UP_LO_ADDR    = 8'h99;
    localparam logic [7:0] PROX_UP_HI_ADDR    = 8'h9A;
    localparam logic [7:0] PROX_LOW_LO_ADDR   = 8'h9B;
    localparam logic [7:0] PROX_LOW_HI_ADDR   = 8'h9C;
    localparam logic [7:0] LIGHT_UP_LO_ADDR   = 8'h9E;
    localparam logic [7:0] LIGHT_UP_HI_ADDR   = 8'h9F;
    localparam logic [7:0] LIGHT_LOW_LO_ADDR  = 8'hA0;
    localparam logic [7:0] LIGHT_LOW_HI_ADDR  = 8'hA1;
    localparam logic [7:0] PERSIST_ADDR       = 8'hA4;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] INT_CTRL_RST       = 8'h08;
    localparam logic [7:0] PROX_UP_LO_RST     = 8'hFF;
    localparam logic [7:0] PROX_UP_HI_RST     = 8'h07;
    localparam logic [7:0] PROX_LOW_LO_RST    = 8'h00;
    localparam logic [7:0] PROX_LOW_HI_RST    = 8'h00;
    localparam logic [7:0] LIGHT_UP_LO_RST    = 8'hFF;
    localparam logic [7:0] LIGHT_UP_HI_RST    = 8'hFF;
    localparam logic [7:0] LIGHT_LOW_LO_RST   = 8'h00;
    localparam logic [7:0] LIGHT_LOW_HI_RST   = 8'h00;
    localparam logic [7:0] PERSIST_RST        = 8'h00;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int PROX_HI_MSB   = 2;
    localparam int CTRL_FIELD_MSB = 3;
    localparam int OUT_MODE_BIT  = 3;
    localparam int POLARITY_BIT  = 2;
    localparam int SRC_PROX_BIT  = 0;
    localparam int SRC_LIGHT_BIT = 1;
    localparam int PROX_PERS_LSB  = 4;
    localparam int LIGHT_PERS_LSB = 0;
endpackage

// File: design/window_check.sv
// Purpose : One channel window compare with persistence counting
// Assumes : RESULT_VALID pulses once per finished measurement
// Notes   : Limits compare directly with the result format
`timescale 1ns/1ps
`default_nettype none
module window_check
    import thresh_pkg::*;
#(
    parameter int W = 16
) (
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic [W-1:0]      result,
    input  wire logic              result_valid,
    input  wire logic [W-1:0]      upper,
    input  wire logic [W-1:0]      lower,
    input  wire logic [PERS_W-1:0] persist,
    output logic                   trig_q,
    output logic                   hit_q,
    output logic                   upd_q
);
    logic [PERS_W-1:0] cnt_q;
    logic [PERS_W-1:0] cnt_d;
    logic              trig_d;
    logic              outside;
    logic [PERS_W-1:0] need;

    // ************************************************************
    // Window compare and persistence
    // ************************************************************
    always_comb begin
        outside = (result > upper) || (result < lower);
        need    = (persist == '0) ? PERS_W'(1) : persist;
        cnt_d   = cnt_q;
        trig_d  = trig_q;
        if (result_valid) begin
            if (outside) begin
                cnt_d  = (cnt_q == '1) ? cnt_q : cnt_q + PERS_W'(1);
                trig_d = (cnt_d >= need);
            end else begin
                cnt_d  = '0;
                trig_d = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_q  <= '0;
            trig_q <= 1'b0;
            hit_q  <= 1'b0;
            upd_q  <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            trig_q <= trig_d;
            hit_q  <= result_valid && trig_d;
            upd_q  <= result_valid;
        end
    end

    inside_clear_a: assert property (@(posedge clk) disable iff (srst)
        result_valid && result <= upper && result >= lower |=> !trig_q && !hit_q)
        else $error("Result inside window raised a condition");
    above_top_a: assert property (@(posedge clk) disable iff (srst)
        result_valid && result > upper && persist <= 4'h1 |=> trig_q && hit_q)
        else $error("Result above upper limit not flagged");
    below_floor_a: assert property (@(posedge clk) disable iff (srst)
        result_valid && result < lower && persist <= 4'h1 |=> trig_q)
        else $error("Result below lower limit not flagged");
    persist_hold_a: assert property (@(posedge clk) disable iff (srst)
        result_valid && cnt_q == '0 && persist > 4'h1 |=> !trig_q)
        else $error("Persistence filter fired on first outside result");
endmodule
`default_nettype wire

// File: design/threshold_window_compare.sv
// Purpose : Threshold limit registers and interrupt condition for two channels
// Assumes : Byte register port driven by the serial register interface
// Notes   : Pin is two signals, level and enable, no inout
// Summary of operation
// - Each channel's upper and lower limit bound one window checked against every new result.
// - A result outside its window raises that channel's condition; one inside raises none.
// - Proximity upper limit is 11 bits, bits 7:0 at 0x99 and bits 10:8 in 0x9A bits 2:0.
// - Proximity lower limit is 11 bits, bits 7:0 at 0x9B and bits 10:8 in 0x9C bits 2:0.
// - Proximity upper limit resets to 0xFF low and 0x07 high.
// - Proximity lower limit resets to 0x00 in both bytes.
// - Light upper limit is 16 bits at 0x9E and 0x9F, both bytes resetting to 0xFF.
// - Light lower limit is 16 bits at 0xA0 and 0xA1, both bytes resetting to 0x00.
// - A two-bit source select gates the pin while status keeps updating.
// - Output mode 0 latches the pin until a status read; mode 1 refreshes it each measurement.
// - A four-bit persistence count per channel needs N consecutive outside results, 0 every one.
`timescale 1ns/1ps
`default_nettype none
module threshold_window_compare
    import thresh_pkg::*;
(
    input  wire logic               SYS_CLK,
    input  wire logic               SRST,
    input  wire logic [7:0]         REG_ADDR,
    input  wire logic [7:0]         REG_WDATA,
    input  wire logic               REG_WR,
    input  wire logic               REG_RD,
    output logic      [7:0]         REG_RDATA,
    input  wire logic [PROX_W-1:0]  PROX_RESULT,
    input  wire logic               PROX_VALID,
    input  wire logic [LIGHT_W-1:0] LIGHT_RESULT,
    input  wire logic               LIGHT_VALID,
    input  wire logic               STATUS_RD,
    output logic                    PROX_STATUS,
    output logic                    LIGHT_STATUS,
    output logic                    INT_O,
    output logic                    INT_OE
);
    logic [7:0] ctrl_q, ctrl_d;
    logic [7:0] pup_lo_q, pup_lo_d, pup_hi_q, pup_hi_d;
    logic [7:0] plo_lo_q, plo_lo_d, plo_hi_q, plo_hi_d;
    logic [7:0] lup_lo_q, lup_lo_d, lup_hi_q, lup_hi_d;
    logic [7:0] llo_lo_q, llo_lo_d, llo_hi_q, llo_hi_d;
    logic [7:0] pers_q, pers_d;
    logic [7:0] rdata_q, rdata_d;
    logic       pin_q, pin_d;
    logic       into_q, into_d;
    logic       inoe_q, inoe_d;
    logic       p_trig, p_hit, p_upd;
    logic       l_trig, l_hit, l_upd;
    logic [PROX_W-1:0]  prox_upper_limit;
    logic [PROX_W-1:0]  prox_lower_limit;
    logic [LIGHT_W-1:0] light_upper_limit;
    logic [LIGHT_W-1:0] light_lower_limit;

    function automatic logic wr_hit(input logic [7:0] a);
        wr_hit = REG_WR && (REG_ADDR == a);
    endfunction

    // ************************************************************
    // Limit assembly
    // ************************************************************
    assign prox_upper_limit  = {pup_hi_q[PROX_HI_MSB:0], pup_lo_q};
    assign prox_lower_limit  = {plo_hi_q[PROX_HI_MSB:0], plo_lo_q};
    assign light_upper_limit = {lup_hi_q, lup_lo_q};
    assign light_lower_limit = {llo_hi_q, llo_lo_q};

    // ************************************************************
    // Channel compare
    // ************************************************************
    window_check #(.W(PROX_W)) u_prox (
        .clk          (SYS_CLK),
        .srst         (SRST),
        .result       (PROX_RESULT),
        .result_valid (PROX_VALID),
        .upper        (prox_upper_limit),
        .lower        (prox_lower_limit),
        .persist      (pers_q[PROX_PERS_LSB +: PERS_W]),
        .trig_q       (p_trig),
        .hit_q        (p_hit),
        .upd_q        (p_upd)
    );

    window_check #(.W(LIGHT_W)) u_light (
        .clk          (SYS_CLK),
        .srst         (SRST),
        .result       (LIGHT_RESULT),
        .result_valid (LIGHT_VALID),
        .upper        (light_upper_limit),
        .lower        (light_lower_limit),
        .persist      (pers_q[LIGHT_PERS_LSB +: PERS_W]),
        .trig_q       (l_trig),
        .hit_q        (l_hit),
        .upd_q        (l_upd)
    );

    // ************************************************************
    // Register writes and reads
    // ************************************************************
    always_comb begin
        ctrl_d   = wr_hit(INT_CTRL_ADDR)
                 ? {4'h0, REG_WDATA[CTRL_FIELD_MSB:0]} : ctrl_q;
        pup_lo_d = wr_hit(PROX_UP_LO_ADDR)  ? REG_WDATA : pup_lo_q;
        pup_hi_d = wr_hit(PROX_UP_HI_ADDR)
                 ? {5'h00, REG_WDATA[PROX_HI_MSB:0]} : pup_hi_q;
        plo_lo_d = wr_hit(PROX_LOW_LO_ADDR) ? REG_WDATA : plo_lo_q;
        plo_hi_d = wr_hit(PROX_LOW_HI_ADDR)
                 ? {5'h00, REG_WDATA[PROX_HI_MSB:0]} : plo_hi_q;
        lup_lo_d = wr_hit(LIGHT_UP_LO_ADDR)  ? REG_WDATA : lup_lo_q;
        lup_hi_d = wr_hit(LIGHT_UP_HI_ADDR)  ? REG_WDATA : lup_hi_q;
        llo_lo_d = wr_hit(LIGHT_LOW_LO_ADDR) ? REG_WDATA : llo_lo_q;
        llo_hi_d = wr_hit(LIGHT_LOW_HI_ADDR) ? REG_WDATA : llo_hi_q;
        pers_d   = wr_hit(PERSIST_ADDR)      ? REG_WDATA : pers_q;
        rdata_d  = rdata_q;
        if (REG_RD) begin
            unique case (REG_ADDR)
                INT_CTRL_ADDR:     rdata_d = ctrl_q;
                PROX_UP_LO_ADDR:   rdata_d = pup_lo_q;
                PROX_UP_HI_ADDR:   rdata_d = pup_hi_q;
                PROX_LOW_LO_ADDR:  rdata_d = plo_lo_q;
                PROX_LOW_HI_ADDR:  rdata_d = plo_hi_q;
                LIGHT_UP_LO_ADDR:  rdata_d = lup_lo_q;
                LIGHT_UP_HI_ADDR:  rdata_d = lup_hi_q;
                LIGHT_LOW_LO_ADDR: rdata_d = llo_lo_q;
                LIGHT_LOW_HI_ADDR: rdata_d = llo_hi_q;
                PERSIST_ADDR:      rdata_d = pers_q;
                default:           rdata_d = 8'h00;
            endcase
        end
    end

    // ************************************************************
    // Interrupt pin
    // ************************************************************
    always_comb begin
        pin_d = pin_q;
        if (ctrl_q[OUT_MODE_BIT]) begin
            if ((p_upd && ctrl_q[SRC_PROX_BIT]) || (l_upd && ctrl_q[SRC_LIGHT_BIT])) begin
                pin_d = (p_trig && ctrl_q[SRC_PROX_BIT])
                     || (l_trig && ctrl_q[SRC_LIGHT_BIT]);
            end
        end else begin
            if ((p_hit && ctrl_q[SRC_PROX_BIT]) || (l_hit && ctrl_q[SRC_LIGHT_BIT])) begin
                pin_d = 1'b1;
            end else if (STATUS_RD) begin
                pin_d = 1'b0;
            end
        end
        if (ctrl_q[SRC_LIGHT_BIT:SRC_PROX_BIT] == 2'b00) begin
            pin_d = 1'b0;
        end
        into_d = ctrl_q[POLARITY_BIT] ? pin_d : !pin_d;
        inoe_d = (ctrl_q[SRC_LIGHT_BIT:SRC_PROX_BIT] != 2'b00);
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            ctrl_q   <= INT_CTRL_RST;
            pup_lo_q <= PROX_UP_LO_RST;
            pup_hi_q <= PROX_UP_HI_RST;
            plo_lo_q <= PROX_LOW_LO_RST;
            plo_hi_q <= PROX_LOW_HI_RST;
            lup_lo_q <= LIGHT_UP_LO_RST;
            lup_hi_q <= LIGHT_UP_HI_RST;
            llo_lo_q <= LIGHT_LOW_LO_RST;
            llo_hi_q <= LIGHT_LOW_HI_RST;
            pers_q   <= PERSIST_RST;
            rdata_q  <= 8'h00;
            pin_q    <= 1'b0;
            into_q   <= 1'b1;
            inoe_q   <= 1'b0;
        end else begin
            ctrl_q   <= ctrl_d;
            pup_lo_q <= pup_lo_d;
            pup_hi_q <= pup_hi_d;
            plo_lo_q <= plo_lo_d;
            plo_hi_q <= plo_hi_d;
            lup_lo_q <= lup_lo_d;
            lup_hi_q <= lup_hi_d;
            llo_lo_q <= llo_lo_d;
            llo_hi_q <= llo_hi_d;
            pers_q   <= pers_d;
            rdata_q  <= rdata_d;
            pin_q    <= pin_d;
            into_q   <= into_d;
            inoe_q   <= inoe_d;
        end
    end

    // Status follows the channels regardless of the source select
    assign REG_RDATA    = rdata_q;
    assign PROX_STATUS  = p_trig;
    assign LIGHT_STATUS = l_trig;
    assign INT_O        = into_q;
    assign INT_OE       = inoe_q;

    // ************************************************************
    // Checks
    // ************************************************************
    prox_hi_write_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
        REG_WR && REG_ADDR == PROX_UP_HI_ADDR |=> pup_hi_q == {5'h00, $past(REG_WDATA[2:0])})
        else $error("Proximity upper high byte not masked to three bits");
    prox_low_hi_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
        REG_WR && REG_ADDR == PROX_LOW_HI_ADDR |=> prox_lower_limit[10:8] == $past(REG_WDATA[2:0]))
        else $error("Proximity lower limit high bits wrong");
    reset_values_a: assert property (@(posedge SYS_CLK)
        $past(SRST) |-> prox_upper_limit == 11'h7FF && prox_lower_limit == 11'h000)
        else $error("Proximity limits wrong after reset");
    light_reset_a: assert property (@(posedge SYS_CLK)
        $past(SRST) |-> light_upper_limit == 16'hFFFF && light_lower_limit == 16'h0000)
        else $error("Light limits wrong after reset");
    pin_disabled_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
        ctrl_q[1:0] == 2'b00 |=> !INT_OE)
        else $error("Pin driven while source select is off");
    latch_hold_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
        pin_q && !ctrl_q[3] && ctrl_q[1:0] != 2'b00 && !STATUS_RD |=> pin_q)
        else $error("Latched pin dropped without status read");
    latch_clear_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
        !ctrl_q[3] && STATUS_RD && !p_hit && !l_hit |=> !pin_q)
        else $error("Status read did not clear latched pin");
    prox_only_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
        ctrl_q[1:0] == 2'b01 && p_hit |=> pin_q && INT_O == $past(ctrl_q[POLARITY_BIT]))
        else $error("Proximity condition did not reach pin");
endmodule
`default_nettype wire

// File: test/host_model.sv
// Purpose : Register host on the far side of the limit registers
// Assumes : Byte strobes driven just after the rising edge
// Notes   : Released address and data lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic       clk,
    input  wire logic [7:0] rdata,
    output logic      [7:0] addr,
    output logic      [7:0] wdata,
    output logic            wr,
    output logic            rd,
    output logic            status_rd
);
    // ************************************************************
    // Register and status accesses
    // ************************************************************
    initial begin
        addr      = 8'h00;
        wdata     = 8'h00;
        wr        = 1'b0;
        rd        = 1'b0;
        status_rd = 1'b0;
    end

    // Caller encodes each limit in its channel's result format
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        addr  <= ~a;
        wdata <= ~d;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        addr <= ~a;
        #1 v = rdata;
    endtask

    task automatic status_read();
        @(posedge clk);
        status_rd <= 1'b1;
        @(posedge clk);
        status_rd <= 1'b0;
    endtask
endmodule
`default_nettype wire

// File: test/threshold_window_compare_tb.sv
// Purpose : Self-checking bench for the threshold window compare block
// Assumes : Status one edge after a valid, pin one edge later
// Notes   : Limits, masks, source select, pin modes and persistence
`timescale 1ns/1ps
`default_nettype none
module threshold_window_compare_tb;
    import thresh_pkg::*;
    logic                sys_clk;
    logic                srst;
    logic [7:0]          reg_addr;
    logic [7:0]          reg_wdata;
    logic                reg_wr;
    logic                reg_rd;
    logic [7:0]          reg_rdata;
    logic [PROX_W-1:0]   prox_result;
    logic                prox_valid;
    logic [LIGHT_W-1:0]  light_result;
    logic                light_valid;
    logic                status_rd;
    logic                prox_status;
    logic                light_status;
    logic                int_o;
    logic                int_oe;
    int                  failures = 0;
    int                  n_tests = 0;

    threshold_window_compare dut_u (.SYS_CLK(sys_clk), .SRST(srst), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
        .PROX_RESULT(prox_result), .PROX_VALID(prox_valid), .LIGHT_RESULT(light_result),
        .LIGHT_VALID(light_valid), .STATUS_RD(status_rd), .PROX_STATUS(prox_status),
        .LIGHT_STATUS(light_status), .INT_O(int_o), .INT_OE(int_oe));

    host_model host_u (.clk(sys_clk), .rdata(reg_rdata), .addr(reg_addr), .wdata(reg_wdata),
        .wr(reg_wr), .rd(reg_rd), .status_rd(status_rd));

    // ************************************************************
    // Helpers
    // ************************************************************
    always #25 sys_clk = ~sys_clk;

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        host_u.rd_reg(a, v);
        check(v, e);
    endtask

    task automatic meas(input logic p, input logic [15:0] v, input logic e);
        logic s;
        @(posedge sys_clk);
        if (p) begin
            prox_valid  <= 1'b1;
            prox_result <= v[10:0];
        end else begin
            light_valid  <= 1'b1;
            light_result <= v;
        end
        @(posedge sys_clk);
        prox_valid   <= 1'b0;
        light_valid  <= 1'b0;
        prox_result  <= ~v[10:0];
        light_result <= ~v;
        #1 s = p ? prox_status : light_status;
        check({7'h00, s}, {7'h00, e});
    endtask

    task automatic pin_chk(input logic o, input logic oe);
        @(posedge sys_clk);
        #1 check({6'h00, int_oe, int_o}, {6'h00, oe, o});
    endtask

    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        sys_clk      = 1'b0;
        srst         = 1'b1;
        prox_valid   = 1'b0;
        light_valid  = 1'b0;
        prox_result  = '0;
        light_result = '0;
        repeat (10) @(posedge sys_clk);
        srst <= 1'b0;
        #1 check({6'h00, int_oe, int_o}, 8'h01);
        rd_chk(PROX_UP_LO_ADDR, 8'hFF);
        rd_chk(PROX_UP_HI_ADDR, 8'h07);
        rd_chk(PROX_LOW_LO_ADDR, 8'h00);
        rd_chk(PROX_LOW_HI_ADDR, 8'h00);
        rd_chk(LIGHT_UP_LO_ADDR, 8'hFF);
        rd_chk(LIGHT_UP_HI_ADDR, 8'hFF);
        rd_chk(LIGHT_LOW_LO_ADDR, 8'h00);
        rd_chk(LIGHT_LOW_HI_ADDR, 8'h00);
        rd_chk(INT_CTRL_ADDR, 8'h08);
        rd_chk(PERSIST_ADDR, 8'h00);
        meas(1'b1, 16'h07FF, 1'b0);
        meas(1'b0, 16'hFFFF, 1'b0);
        $display("test reset values done");
        host_u.wr_reg(PROX_UP_HI_ADDR, 8'hF9);
        rd_chk(PROX_UP_HI_ADDR, 8'h01);
        host_u.wr_reg(PROX_UP_LO_ADDR, 8'h23);
        host_u.wr_reg(PROX_LOW_LO_ADDR, 8'h45);
        host_u.wr_reg(PROX_LOW_HI_ADDR, 8'hF8);
        rd_chk(PROX_LOW_HI_ADDR, 8'h00);
        host_u.wr_reg(8'h9D, 8'h5A);
        rd_chk(8'h9D, 8'h00);
        meas(1'b1, 16'h0123, 1'b0);
        meas(1'b1, 16'h0124, 1'b1);
        meas(1'b1, 16'h0045, 1'b0);
        meas(1'b1, 16'h0044, 1'b1);
        meas(1'b1, 16'h00A0, 1'b0);
        $display("test proximity window done");
        host_u.wr_reg(LIGHT_UP_LO_ADDR, 8'hCD);
        host_u.wr_reg(LIGHT_UP_HI_ADDR, 8'hAB);
        host_u.wr_reg(LIGHT_LOW_LO_ADDR, 8'h34);
        host_u.wr_reg(LIGHT_LOW_HI_ADDR, 8'h12);
        meas(1'b0, 16'hABCD, 1'b0);
        meas(1'b0, 16'hABCE, 1'b1);
        meas(1'b0, 16'h1234, 1'b0);
        meas(1'b0, 16'h1233, 1'b1);
        meas(1'b0, 16'h8000, 1'b0);
        $display("test light window done");
        for (int s = 0; s < 4; s++) begin
            host_u.wr_reg(INT_CTRL_ADDR, 8'h08 | 8'(s));
            meas(1'b1, 16'h0200, 1'b1);
            meas(1'b0, 16'h8000, 1'b0);
            pin_chk(~s[0], s != 0);
        end
        meas(1'b1, 16'h0100, 1'b0);
        $display("test source select done");
        host_u.wr_reg(INT_CTRL_ADDR, 8'h03);
        meas(1'b1, 16'h0200, 1'b1);
        pin_chk(1'b0, 1'b1);
        meas(1'b1, 16'h0100, 1'b0);
        pin_chk(1'b0, 1'b1);
        host_u.status_read();
        pin_chk(1'b1, 1'b1);
        host_u.wr_reg(INT_CTRL_ADDR, 8'h0B);
        meas(1'b1, 16'h0200, 1'b1);
        pin_chk(1'b0, 1'b1);
        meas(1'b1, 16'h0100, 1'b0);
        pin_chk(1'b1, 1'b1);
        $display("test output mode done");
        host_u.wr_reg(PERSIST_ADDR, 8'h30);
        rd_chk(PERSIST_ADDR, 8'h30);
        meas(1'b1, 16'h0200, 1'b0);
        meas(1'b1, 16'h0200, 1'b0);
        meas(1'b1, 16'h0200, 1'b1);
        meas(1'b1, 16'h0100, 1'b0);
        meas(1'b1, 16'h0200, 1'b0);
        host_u.wr_reg(PERSIST_ADDR, 8'h02);
        rd_chk(PERSIST_ADDR, 8'h02);
        meas(1'b0, 16'hABCE, 1'b0);
        meas(1'b0, 16'hABCE, 1'b1);
        $display("test persistence done");
        host_u.wr_reg(INT_CTRL_ADDR, 8'hFF);
        rd_chk(INT_CTRL_ADDR, 8'h0F);
        meas(1'b1, 16'h0200, 1'b1);
        pin_chk(1'b1, 1'b1);
        meas(1'b0, 16'h8000, 1'b0);
        meas(1'b1, 16'h0100, 1'b0);
        pin_chk(1'b0, 1'b1);
        $display("test polarity done");
        print_verdict();
    end

    initial begin
        #1000000;
        failures++;
        print_verdict();
    end
endmodule
`default_nettype wire
